// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import wdt_pkg::*;
;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, wdt_reset_out, irq, err;
    logic [1:0]  osc_div = 2'h0;
    int          n_mismatch = 0, checked = 0, t, len;

    wdt_top i_wdt_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_clk_in(osc), .wdt_reset_out(wdt_reset_out), .irq(irq));

    initial forever #10 clk = ~clk;

    // oscillator period of 8 clocks, so a 256-edge pulse is 2048 clocks
    always @(posedge clk) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div == 2'h3) osc <= ~osc;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("Error pready expected 1 seen %b", pready);
        end
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdata);
    endtask : rd

    task automatic wait_rise(input int lim);
        t = 0;
        while (wdt_reset_out !== 1'b1 && t < lim) begin
            @(posedge clk);
            t++;
        end
    endtask : wait_rise

    task automatic wait_fall;
        len = 0;
        while (wdt_reset_out === 1'b1 && len < 3000) begin
            @(posedge clk);
            len++;
        end
    endtask : wait_fall

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // run of at most about 52000 clocks; limit well above it
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(WDT_COUNT_OFF, 32'h0, "count reset");
        rd(WDT_CLKSEL_OFF, 32'hFF, "select reset");
        rd(WDT_CSR_OFF, 32'hAA, "csr reset");
        wr(WDT_COUNT_OFF, 32'h5A);
        rd(WDT_COUNT_OFF, 32'h0, "count locked");
        wr(WDT_CSR_OFF, 32'hEA);
        rd(WDT_CSR_OFF, 32'hAA, "guarded unlock");
        wr(WDT_CSR_OFF, 32'h6A);
        wr(WDT_COUNT_OFF, 32'h5A);
        rd(WDT_COUNT_OFF, 32'h5A, "count written");
        wr(WDT_CSR_OFF, 32'hA6);
        rd(WDT_CSR_OFF, 32'hEA, "run locked");
        wr(WDT_CSR_OFF, 32'h9A);
        wr(WDT_CSR_OFF, 32'hA6);
        rd(WDT_CSR_OFF, 32'hFE, "run on");
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        for (int k = 0; k < 8; k++) begin
            wr(WDT_CLKSEL_OFF, 32'h8 + 32'(k));
            rd(WDT_CLKSEL_OFF, 32'hF8 + 32'(k), "select");
            wr(WDT_COUNT_OFF, 32'hFE);
            wait_rise(20000);
            chk("tap period", 32'h1, 32'(t > (64 << k) - 8 && t <= (128 << k) + 8));
            wait_fall();
            chk("pulse length", 32'h1, 32'(len >= 2040 && len <= 2056));
            rd(WDT_CSR_OFF, 32'hFF, "flag set");
            wr(WDT_CSR_OFF, 32'hA8);
            rd(WDT_CSR_OFF, 32'hFE, "flag clear");
        end
        wr(WDT_CLKSEL_OFF, 32'h3);
        wr(WDT_COUNT_OFF, 32'hFF);
        wait_rise(40);
        chk("osc tick", 32'h1, 32'(t <= 14));
        // stop counting so no second overflow lands in the irq checks
        wr(WDT_CSR_OFF, 32'hA2);
        rd(WDT_CSR_OFF, 32'hFB, "run off");
        wait_fall();
        rd(WDT_IRQ_STAT_OFF, 32'h3, "irq status");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(WDT_IRQ_MASK_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(WDT_IRQ_STAT_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(WDT_IRQ_STAT_OFF, 32'h2, "status w1c");
        wr(WDT_IRQ_MASK_OFF, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq mask off", 32'h0, {31'h0, irq});
        // mid-run pin reset must stop a running watchdog and drop its flag
        wr(WDT_CSR_OFF, 32'hA6);
        rd(WDT_CSR_OFF, 32'hFF, "run again");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(WDT_CSR_OFF, 32'hAA, "csr pin reset");
        rd(WDT_COUNT_OFF, 32'h0, "count pin reset");
        rd(WDT_CLKSEL_OFF, 32'hFF, "select pin reset");
        stop_test();
    end
endmodule : tb
`default_nettype wire

// ### wdt_osc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_osc_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic osc_in,
    wdt_tick_if.src   tick_out
);
    logic s1;
    logic s2;
    logic s3;
    logic next_tick;

    // rising edge taken from the second and third stages
    always_comb begin
        next_tick = s2 & ~s3;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1            <= 1'b0;
            s2            <= 1'b0;
            s3            <= 1'b0;
            tick_out.tick <= 1'b0;
        end else begin
            s1            <= osc_in;
            s2            <= s1;
            s3            <= s2;
            tick_out.tick <= next_tick;
        end
    end
endmodule : wdt_osc_sync
`default_nettype wire

// ### wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] WDT_CSR_OFF      = 8'h00;
    localparam logic [7:0] WDT_COUNT_OFF    = 8'h04;
    localparam logic [7:0] WDT_CLKSEL_OFF   = 8'h08;
    localparam logic [7:0] WDT_IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] WDT_IRQ_MASK_OFF = 8'h10;

    // ------------------------------------------------------------
    // control/status field positions
    // ------------------------------------------------------------
    localparam int WDT_CNT_GUARD_BIT  = 7;
    localparam int WDT_CNT_UNLK_BIT   = 6;
    localparam int WDT_CTL_GUARD_BIT  = 5;
    localparam int WDT_CTL_UNLK_BIT   = 4;
    localparam int WDT_RUN_GUARD_BIT  = 3;
    localparam int WDT_RUN_BIT        = 2;
    localparam int WDT_FLAG_GUARD_BIT = 1;
    localparam int WDT_FLAG_BIT       = 0;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int WDT_IRQ_OVF_BIT  = 0;
    localparam int WDT_IRQ_DONE_BIT = 1;
    localparam int WDT_IRQ_W        = 2;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0]  WDT_COUNT_RST     = 8'h00;
    localparam logic [7:0]  WDT_COUNT_MAX     = 8'hFF;
    localparam logic [3:0]  WDT_CLKSEL_RST    = 4'hF;
    localparam logic [3:0]  WDT_CLKSEL_RSVD   = 4'hF;
    localparam logic [7:0]  WDT_GUARD_READ    = 8'hAA;
    localparam int          WDT_PRESC_SHIFT   = 6;
    localparam int          WDT_PRESC_W       = 13;
    localparam int          WDT_RST_OSC_TICKS = 256;
    localparam logic [8:0]  WDT_RST_LEN       = 9'h100;

endpackage : wdt_pkg

// ### wdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
    import wdt_pkg::*;
#(
    parameter int W = WDT_PRESC_W
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] tap_sel,
    wdt_tick_if.src         tick_out
);
    logic [W-1:0] div_cnt;
    logic [W-1:0] next_div_cnt;
    logic [W-1:0] mask;
    logic         next_tick;

    always_comb begin
        next_div_cnt = div_cnt + {{(W-1){1'b0}}, 1'b1};
        mask         = W'((1 << (WDT_PRESC_SHIFT + int'(tap_sel))) - 1);
        // tap of 2^(6+sel): one pulse per period, never a derived clock
        next_tick    = ((div_cnt & mask) == mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt       <= '0;
            tick_out.tick <= 1'b0;
        end else begin
            div_cnt       <= next_div_cnt;
            tick_out.tick <= next_tick;
        end
    end
endmodule : wdt_prescaler
`default_nettype wire

// ### wdt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdt_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : wdt_tick_if
`default_nettype wire

// ### wdt_top.sv
// What this block does
// - 8-bit counter; wrap FF to 00 raises internal reset and sets flag.
// - reset loads counter with zero.
// - clock select 1000..1111 picks clk/64..clk/8192; 0xxx picks oscillator.
// - clock-select bits 7 to 4 always read as one.
// - run set only by write run=1, guard=0, control unlock already 1.
// - internal reset held exactly 256 oscillator cycles after overflow.
// - counter write makes counting continue from written value.
// - counter writes need counter unlock; unlock written only with guard bit 7 zero.
// - run and flag written only while control unlock; unlock needs guard bit 5 zero.
// - reset clears run and flag; guarded zero write while unlocked clears them.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_clk_in,
    output logic             wdt_reset_out,
    output logic             irq
);
    // ------------------------------------------------------------
    // tick sources
    // ------------------------------------------------------------
    wdt_tick_if presc_if ();
    wdt_tick_if osc_if ();

    logic [3:0] clk_sel;

    wdt_prescaler u_presc (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .tap_sel  (clk_sel[2:0]),
        .tick_out (presc_if.src)
    );

    wdt_osc_sync u_osc (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .osc_in   (osc_clk_in),
        .tick_out (osc_if.src)
    );

    logic cnt_tick;

    always_comb begin
        cnt_tick = clk_sel[3] ? presc_if.tick : osc_if.tick;
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic        bus_done;
    logic        wr_done;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;
    logic        addr_ok;

    always_comb begin
        addr_ok = (paddr == WDT_CSR_OFF) || (paddr == WDT_COUNT_OFF) ||
                  (paddr == WDT_CLKSEL_OFF) || (paddr == WDT_IRQ_STAT_OFF) ||
                  (paddr == WDT_IRQ_MASK_OFF);
        bus_done     = psel & penable & pready;
        wr_done      = bus_done & pwrite & addr_ok;
        // one wait state: answer registered from the first access cycle
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & ~addr_ok;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]          count;
    logic                cnt_unlock;
    logic                ctl_unlock;
    logic                run;
    logic                flag;
    logic [WDT_IRQ_W-1:0] irq_stat;
    logic [WDT_IRQ_W-1:0] irq_mask;
    logic [8:0]          rst_left;

    logic [7:0]          next_count;
    logic                next_cnt_unlock;
    logic                next_ctl_unlock;
    logic                next_run;
    logic                next_flag;
    logic [3:0]          next_clk_sel;
    logic [WDT_IRQ_W-1:0] next_irq_stat;
    logic [WDT_IRQ_W-1:0] next_irq_mask;
    logic [8:0]          next_rst_left;
    logic                next_irq;
    logic                overflow;
    logic                pulse_end;
    logic [7:0]          wb;
    logic [7:0]          csr_read;

    always_comb begin
        wb       = pwdata[7:0];
        csr_read = WDT_GUARD_READ;
        csr_read[WDT_CNT_UNLK_BIT] = cnt_unlock;
        csr_read[WDT_CTL_UNLK_BIT] = ctl_unlock;
        csr_read[WDT_RUN_BIT]      = run;
        csr_read[WDT_FLAG_BIT]     = flag;

        next_prdata = 32'h0000_0000;
        if (next_pready && !pwrite) begin
            unique case (paddr)
                WDT_CSR_OFF:      next_prdata[7:0] = csr_read;
                WDT_COUNT_OFF:    next_prdata[7:0] = count;
                WDT_CLKSEL_OFF:   next_prdata[7:0] = {WDT_CLKSEL_RSVD, clk_sel};
                WDT_IRQ_STAT_OFF: next_prdata[WDT_IRQ_W-1:0] = irq_stat;
                WDT_IRQ_MASK_OFF: next_prdata[WDT_IRQ_W-1:0] = irq_mask;
                default:          next_prdata = 32'h0000_0000;
            endcase
        end

        overflow   = run && cnt_tick && (count == WDT_COUNT_MAX);
        next_count = count;
        if (run && cnt_tick) begin
            next_count = count + 8'h01;
        end
        // guarded preload wins over the tick
        if (wr_done && paddr == WDT_COUNT_OFF && cnt_unlock) begin
            next_count = wb;
        end

        next_cnt_unlock = cnt_unlock;
        next_ctl_unlock = ctl_unlock;
        next_run        = run;
        next_flag       = flag;
        if (wr_done && paddr == WDT_CSR_OFF) begin
            if (!wb[WDT_CNT_GUARD_BIT]) begin
                next_cnt_unlock = wb[WDT_CNT_UNLK_BIT];
            end
            if (!wb[WDT_CTL_GUARD_BIT]) begin
                next_ctl_unlock = wb[WDT_CTL_UNLK_BIT];
            end
            if (ctl_unlock && !wb[WDT_RUN_GUARD_BIT]) begin
                next_run = wb[WDT_RUN_BIT];
            end
            if (ctl_unlock && !wb[WDT_FLAG_GUARD_BIT]) begin
                next_flag = wb[WDT_FLAG_BIT];
            end
        end
        // overflow sets flag, beats a clear
        if (overflow) begin
            next_flag = 1'b1;
        end

        next_clk_sel = clk_sel;
        if (wr_done && paddr == WDT_CLKSEL_OFF) begin
            next_clk_sel = wb[3:0];
        end

        next_rst_left = rst_left;
        pulse_end     = 1'b0;
        if (overflow) begin
            next_rst_left = WDT_RST_LEN;
        end else if (rst_left != 9'h000 && osc_if.tick) begin
            next_rst_left = rst_left - 9'h001;
            pulse_end     = (rst_left == 9'h001);
        end

        next_irq_mask = irq_mask;
        if (wr_done && paddr == WDT_IRQ_MASK_OFF) begin
            next_irq_mask = pwdata[WDT_IRQ_W-1:0];
        end
        next_irq_stat = irq_stat;
        if (wr_done && paddr == WDT_IRQ_STAT_OFF) begin
            next_irq_stat = irq_stat & ~pwdata[WDT_IRQ_W-1:0];
        end
        // events set after the clear so a same-cycle event survives
        if (overflow) begin
            next_irq_stat[WDT_IRQ_OVF_BIT] = 1'b1;
        end
        if (pulse_end) begin
            next_irq_stat[WDT_IRQ_DONE_BIT] = 1'b1;
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count         <= WDT_COUNT_RST;
            cnt_unlock    <= 1'b0;
            ctl_unlock    <= 1'b0;
            run           <= 1'b0;
            flag          <= 1'b0;
            clk_sel       <= WDT_CLKSEL_RST;
            rst_left      <= 9'h000;
            irq_stat      <= '0;
            irq_mask      <= '0;
            irq           <= 1'b0;
            wdt_reset_out <= 1'b0;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            prdata        <= 32'h0000_0000;
        end else begin
            count         <= next_count;
            cnt_unlock    <= next_cnt_unlock;
            ctl_unlock    <= next_ctl_unlock;
            run           <= next_run;
            flag          <= next_flag;
            clk_sel       <= next_clk_sel;
            rst_left      <= next_rst_left;
            irq_stat      <= next_irq_stat;
            irq_mask      <= next_irq_mask;
            irq           <= next_irq;
            wdt_reset_out <= (next_rst_left != 9'h000);
            pready        <= next_pready;
            pslverr       <= next_pslverr;
            prdata        <= next_prdata;
        end
    end
endmodule : wdt_top
`default_nettype wire

// ### wdt_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_top_assertions
    import wdt_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        osc_clk_in,
    input wire logic        wdt_reset_out,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // bus and output relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    wire logic rd_ok = pready && !pwrite && !pslverr;

    a_ready_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready missing in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("pready without a transfer");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_clksel_rsvd: assert property (rd_ok && paddr == WDT_CLKSEL_OFF
        |-> prdata[7:4] == 4'hF)
        else $error("reserved select bits not one");
    a_guard_ones: assert property (rd_ok && paddr == WDT_CSR_OFF
        |-> (prdata[7:0] & WDT_GUARD_READ) == WDT_GUARD_READ)
        else $error("guard bits not read as one");
    a_pulse_min: assert property ($rose(wdt_reset_out) |-> wdt_reset_out [*8])
        else $error("internal reset pulse too short");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && !wdt_reset_out && !pready)
        else $error("outputs active after reset");
    a_mask_off: assert property (pready && pwrite && paddr == WDT_IRQ_MASK_OFF
        && pwdata[1:0] == 2'b00 |=> ##1 !irq)
        else $error("irq high with mask cleared");
endmodule : wdt_top_assertions

bind wdt_top wdt_top_assertions i_wdt_top_assertions (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_in(osc_clk_in), .wdt_reset_out(wdt_reset_out), .irq(irq));
`default_nettype wire
